/* File: hdl/sfr_bank.sv */
// Device-specific SFR bank: flash erase control, flash write redirect, read-out
// protection, EEPROM master data and command, multi-purpose flags and interrupt view.
// Assumes the core presents one-cycle SFR read and write strobes on CLK.
//
// Contract
// - Pattern 0x55 starts page erase after select
// - Pattern 0xAA mass erases if enabled, debug
// - Other trigger values are ignored entirely
// - Page select holds page 0-127, resets zero
// - Command write launches EEPROM byte transmission
// - Write enable steers data stores into flash
// - Write enable clears after each flash byte
// - Write enable writes blocked while interrupts enabled
// - Mass erase enable one-shot, resets disabled
// - Protect bit set-only, cleared by reset
// - Status bit reads one during pre-boot
// - Transfer event sets transfer flag
// - Seconds tick sets one-second flag
// - Restart bit reads clock-loss flag, zero clears
// - Writing one restarts the watchdog
// - Interrupt view returns live input levels
module sfr_bank (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic IRQ_GLOBAL_EN,
    input wire logic DEBUG_PORT_EN,
    input wire logic PREBOOT_ACTIVE,
    input wire logic FLASH_BYTE_DONE,
    input wire logic TRANSFER_BUSY_EVENT,
    input wire logic SECONDS_TICK_EVENT,
    input wire logic CLOCK_LOSS_EVENT,
    input wire logic [6:0] EXT_IRQ_LINES,
    input wire logic [7:0] EEPROM_STATUS,
    output logic PAGE_ERASE_START,
    output logic MASS_ERASE_START,
    output logic [6:0] ERASE_PAGE,
    output logic PROGRAM_SPACE_WRITE_ENABLE,
    output logic READOUT_PROTECT,
    output logic [7:0] EEPROM_DATA,
    output logic [7:0] EEPROM_COMMAND,
    output logic EEPROM_LAUNCH,
    output logic WATCHDOG_RESTART,
    output logic TRANSFER_IRQ_FLAG,
    output logic ONE_SECOND_IRQ_FLAG,
    output logic CLOCK_LOSS_FLAG
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [6:0] page_r;
        logic page_fresh_r;
        logic meen_r;
        logic pwe_r;
        logic protect_r;
        logic [7:0] ee_data_r;
        logic [7:0] ee_cmd_r;
        logic ee_launch_r;
        logic page_start_r;
        logic mass_start_r;
        logic wd_restart_r;
        logic [7:0] rdata_r;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;

    logic [6:0] irq_view;
    logic preboot_sync;
    logic debug_sync;
    logic xfer_flag;
    logic sec_flag;
    logic loss_flag;
    logic wr_erase;
    logic wr_flash;
    logic wr_multi;
    logic multi_clr_xfer;
    logic multi_clr_sec;
    logic multi_clr_loss;

    // ==========================================================
    // Pin synchronisers
    sync_two_ff #(
        .WIDTH(sfr_bank_pkg::IRQ_LINES + 2)
    ) u_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .async_in({EXT_IRQ_LINES, PREBOOT_ACTIVE, DEBUG_PORT_EN}),
        .sync_out({irq_view, preboot_sync, debug_sync})
    );

    // ==========================================================
    // Write decode
    assign wr_erase = SFR_WR && (SFR_ADDR == sfr_bank_pkg::ADDR_ERASE_TRIGGER);
    assign wr_flash = SFR_WR && (SFR_ADDR == sfr_bank_pkg::ADDR_FLASH_CONTROL);
    assign wr_multi = SFR_WR && (SFR_ADDR == sfr_bank_pkg::ADDR_MULTI_FLAG);
    assign multi_clr_xfer = wr_multi && !SFR_WDATA[sfr_bank_pkg::BIT_XFER_FLAG];
    assign multi_clr_sec = wr_multi && !SFR_WDATA[sfr_bank_pkg::BIT_SEC_FLAG];
    assign multi_clr_loss = wr_multi && !SFR_WDATA[sfr_bank_pkg::BIT_WD_RESTART];

    // ==========================================================
    // Event flags
    event_flag u_xfer_flag (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .set_evt(TRANSFER_BUSY_EVENT),
        .clr_evt(multi_clr_xfer),
        .flag(xfer_flag)
    );

    event_flag u_sec_flag (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .set_evt(SECONDS_TICK_EVENT),
        .clr_evt(multi_clr_sec),
        .flag(sec_flag)
    );

    event_flag u_loss_flag (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .set_evt(CLOCK_LOSS_EVENT),
        .clr_evt(multi_clr_loss),
        .flag(loss_flag)
    );

    // ==========================================================
    // Register next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ee_launch_r = 1'b0;
        st_nxt.page_start_r = 1'b0;
        st_nxt.mass_start_r = 1'b0;
        st_nxt.wd_restart_r = 1'b0;
        if (FLASH_BYTE_DONE)
        begin
            st_nxt.pwe_r = 1'b0;
        end
        if (SFR_WR)
        begin
            unique case (SFR_ADDR)
                sfr_bank_pkg::ADDR_ERASE_TRIGGER:
                begin
                    if (SFR_WDATA == sfr_bank_pkg::PATTERN_PAGE_ERASE)
                    begin
                        st_nxt.page_start_r = st_r.page_fresh_r;
                        st_nxt.page_fresh_r = 1'b0;
                    end
                    else if (SFR_WDATA == sfr_bank_pkg::PATTERN_MASS_ERASE)
                    begin
                        st_nxt.mass_start_r = st_r.meen_r && debug_sync;
                        st_nxt.meen_r = 1'b0;
                    end
                    // Other patterns change nothing
                end
                sfr_bank_pkg::ADDR_PAGE_SELECT:
                begin
                    st_nxt.page_r = SFR_WDATA[sfr_bank_pkg::PAGE_BITS-1:0];
                    st_nxt.page_fresh_r = 1'b1;
                end
                sfr_bank_pkg::ADDR_EEPROM_DATA:
                begin
                    st_nxt.ee_data_r = SFR_WDATA;
                end
                sfr_bank_pkg::ADDR_EEPROM_CMD:
                begin
                    st_nxt.ee_cmd_r = SFR_WDATA;
                    st_nxt.ee_launch_r = 1'b1;
                end
                sfr_bank_pkg::ADDR_FLASH_CONTROL:
                begin
                    if (!IRQ_GLOBAL_EN)
                    begin
                        st_nxt.pwe_r = SFR_WDATA[sfr_bank_pkg::BIT_PWE];
                    end
                    st_nxt.meen_r = SFR_WDATA[sfr_bank_pkg::BIT_MEEN];
                    if (SFR_WDATA[sfr_bank_pkg::BIT_PROTECT])
                    begin
                        st_nxt.protect_r = 1'b1;
                    end
                end
                sfr_bank_pkg::ADDR_MULTI_FLAG:
                begin
                    st_nxt.wd_restart_r = SFR_WDATA[sfr_bank_pkg::BIT_WD_RESTART];
                end
                default:
                begin
                end
            endcase
        end
        // Read mux, registered
        st_nxt.rdata_r = sfr_bank_pkg::RESET_BYTE;
        if (SFR_RD)
        begin
            unique case (SFR_ADDR)
                sfr_bank_pkg::ADDR_PAGE_SELECT:
                    st_nxt.rdata_r = {1'b0, st_r.page_r};
                sfr_bank_pkg::ADDR_EEPROM_DATA:
                    st_nxt.rdata_r = st_r.ee_data_r;
                sfr_bank_pkg::ADDR_EEPROM_CMD:
                    st_nxt.rdata_r = EEPROM_STATUS;
                sfr_bank_pkg::ADDR_FLASH_CONTROL:
                    st_nxt.rdata_r = {preboot_sync, st_r.protect_r, 5'b0_0000,
                        st_r.pwe_r};
                sfr_bank_pkg::ADDR_MULTI_FLAG:
                    st_nxt.rdata_r = {loss_flag, 5'b0_0000, sec_flag, xfer_flag};
                sfr_bank_pkg::ADDR_IRQ_VIEW:
                    st_nxt.rdata_r = {1'b0, irq_view};
                default:
                    st_nxt.rdata_r = sfr_bank_pkg::RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign SFR_RDATA = st_r.rdata_r;
    assign PAGE_ERASE_START = st_r.page_start_r;
    assign MASS_ERASE_START = st_r.mass_start_r;
    assign ERASE_PAGE = st_r.page_r;
    assign PROGRAM_SPACE_WRITE_ENABLE = st_r.pwe_r;
    assign READOUT_PROTECT = st_r.protect_r;
    assign EEPROM_DATA = st_r.ee_data_r;
    assign EEPROM_COMMAND = st_r.ee_cmd_r;
    assign EEPROM_LAUNCH = st_r.ee_launch_r;
    assign WATCHDOG_RESTART = st_r.wd_restart_r;
    assign TRANSFER_IRQ_FLAG = xfer_flag;
    assign ONE_SECOND_IRQ_FLAG = sec_flag;
    assign CLOCK_LOSS_FLAG = loss_flag;

    // ==========================================================
    // Assertions
    sequence page_sel_write_s;
        SFR_WR && SFR_ADDR == sfr_bank_pkg::ADDR_PAGE_SELECT;
    endsequence

    sequence page_trig_write_s;
        SFR_WR && SFR_ADDR == sfr_bank_pkg::ADDR_ERASE_TRIGGER
            && SFR_WDATA == sfr_bank_pkg::PATTERN_PAGE_ERASE;
    endsequence

    page_erase_start_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        page_sel_write_s ##1 (!wr_erase) [*1] ##1 page_trig_write_s |=> PAGE_ERASE_START)
        else $error("Page erase did not start after select and pattern");

    mass_erase_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        MASS_ERASE_START |-> $past(st_r.meen_r) && $past(debug_sync)
            && $past(wr_erase) && $past(SFR_WDATA) == sfr_bank_pkg::PATTERN_MASS_ERASE)
        else $error("Mass erase started without enable, debug or pattern");

    other_pattern_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_erase && SFR_WDATA != sfr_bank_pkg::PATTERN_PAGE_ERASE
            && SFR_WDATA != sfr_bank_pkg::PATTERN_MASS_ERASE
            |=> !PAGE_ERASE_START && !MASS_ERASE_START && $stable(st_r.page_fresh_r))
        else $error("Unknown erase pattern had an effect");

    page_once_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        PAGE_ERASE_START |-> !st_r.page_fresh_r)
        else $error("Page select stayed fresh after an erase");

    eeprom_launch_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        SFR_WR && SFR_ADDR == sfr_bank_pkg::ADDR_EEPROM_CMD
            |=> EEPROM_LAUNCH && EEPROM_COMMAND == $past(SFR_WDATA)
            ##1 (!EEPROM_LAUNCH || $past(SFR_WR && SFR_ADDR == sfr_bank_pkg::ADDR_EEPROM_CMD)))
        else $error("EEPROM command write did not launch once");

    pwe_autoclear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        FLASH_BYTE_DONE && !(wr_flash && !IRQ_GLOBAL_EN) |=> !PROGRAM_SPACE_WRITE_ENABLE)
        else $error("Write enable did not clear after flash byte");

    pwe_blocked_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_flash && IRQ_GLOBAL_EN && !FLASH_BYTE_DONE |=> $stable(PROGRAM_SPACE_WRITE_ENABLE))
        else $error("Write enable changed while interrupts enabled");

    protect_sticky_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        READOUT_PROTECT |=> READOUT_PROTECT)
        else $error("Protect bit cleared without reset");

    flag_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        TRANSFER_BUSY_EVENT |=> TRANSFER_IRQ_FLAG [*1])
        else $error("Transfer event did not set its flag");

    loss_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        multi_clr_loss && !CLOCK_LOSS_EVENT |=> !CLOCK_LOSS_FLAG)
        else $error("Clock-loss flag not cleared by zero write");

    wd_restart_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_multi && SFR_WDATA[sfr_bank_pkg::BIT_WD_RESTART] |=> WATCHDOG_RESTART)
        else $error("Watchdog restart not pulsed");

    wd_quiet_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !(wr_multi && SFR_WDATA[sfr_bank_pkg::BIT_WD_RESTART]) |=> !WATCHDOG_RESTART)
        else $error("Watchdog restart pulsed without a one write");

    sec_flag_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        SECONDS_TICK_EVENT |=> ONE_SECOND_IRQ_FLAG)
        else $error("Seconds tick did not set its flag");

    sec_flag_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        multi_clr_sec && !SECONDS_TICK_EVENT |=> !ONE_SECOND_IRQ_FLAG)
        else $error("One-second flag not cleared by zero write");

    xfer_flag_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        multi_clr_xfer && !TRANSFER_BUSY_EVENT |=> !TRANSFER_IRQ_FLAG)
        else $error("Transfer flag not cleared by zero write");

    loss_flag_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CLOCK_LOSS_EVENT |=> CLOCK_LOSS_FLAG)
        else $error("Clock-loss event did not set its flag");

    protect_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_flash && SFR_WDATA[sfr_bank_pkg::BIT_PROTECT] |=> READOUT_PROTECT)
        else $error("Protect bit not set by one write");

    pwe_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_flash && !IRQ_GLOBAL_EN
            |=> PROGRAM_SPACE_WRITE_ENABLE == $past(SFR_WDATA[sfr_bank_pkg::BIT_PWE]))
        else $error("Write enable did not take the written value");

    mass_enable_spent_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_erase && SFR_WDATA == sfr_bank_pkg::PATTERN_MASS_ERASE |=> !st_r.meen_r)
        else $error("Mass erase enable survived an erase pattern");

    page_latch_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        page_sel_write_s |=> ERASE_PAGE == $past(SFR_WDATA[sfr_bank_pkg::PAGE_BITS-1:0]))
        else $error("Page select did not hold the written page");

    preboot_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        SFR_RD && SFR_ADDR == sfr_bank_pkg::ADDR_FLASH_CONTROL
            |=> SFR_RDATA[sfr_bank_pkg::BIT_PREBOOT] == $past(preboot_sync))
        else $error("Pre-boot status read wrong");

    irq_view_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        SFR_RD && SFR_ADDR == sfr_bank_pkg::ADDR_IRQ_VIEW
            |=> SFR_RDATA[sfr_bank_pkg::IRQ_LINES-1:0] == $past(irq_view))
        else $error("Interrupt view read wrong");
endmodule : sfr_bank

/* File: hdl/sfr_bank_pkg.sv */
// Package with the addresses, bit positions and codes of the device-specific SFR bank.
// Assumes an 8-bit SFR bus with one-cycle read and write strobes.
package sfr_bank_pkg;
    // ==========================================================
    // SFR addresses
    localparam logic [7:0] ADDR_ERASE_TRIGGER = 8'h94;
    localparam logic [7:0] ADDR_EEPROM_DATA = 8'h9E;
    localparam logic [7:0] ADDR_EEPROM_CMD = 8'h9F;
    localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hB2;
    localparam logic [7:0] ADDR_PAGE_SELECT = 8'hB7;
    localparam logic [7:0] ADDR_MULTI_FLAG = 8'hE8;
    localparam logic [7:0] ADDR_IRQ_VIEW = 8'hF8;
    // ==========================================================
    // Erase patterns
    localparam logic [7:0] PATTERN_PAGE_ERASE = 8'h55;
    localparam logic [7:0] PATTERN_MASS_ERASE = 8'hAA;
    // ==========================================================
    // Field positions
    localparam int BIT_PWE = 0;
    localparam int BIT_MEEN = 1;
    localparam int BIT_PROTECT = 6;
    localparam int BIT_PREBOOT = 7;
    localparam int BIT_XFER_FLAG = 0;
    localparam int BIT_SEC_FLAG = 1;
    localparam int BIT_WD_RESTART = 7;
    // ==========================================================
    // Widths, ranges and reset values
    localparam int PAGE_BITS = 7;
    localparam int IRQ_LINES = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BUS_WIDTH_ONE = 8'h01;
endpackage : sfr_bank_pkg

/* File: hdl/sync_two_ff.sv */
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to CLK.
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta_r;
        logic [WIDTH-1:0] out_r;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    always_comb
    begin
        state_nxt.meta_r = async_in;
        state_nxt.out_r = state_r.meta_r;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.out_r;
endmodule : sync_two_ff

/* File: hdl/event_flag.sv */
// Sticky flag set by a hardware event and cleared by a write strobe; set wins.
// Assumes event and clear come from CLK-domain logic.
module event_flag (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic set_evt,
    input wire logic clr_evt,
    output logic flag
);
    typedef struct packed {
        logic flag_r;
    } flag_state_t;

    flag_state_t state_r;
    flag_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (set_evt)
        begin
            state_nxt.flag_r = 1'b1;
        end
        else if (clr_evt)
        begin
            state_nxt.flag_r = 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign flag = state_r.flag_r;
endmodule : event_flag

/* File: sim/sfr_core_model.sv */
// Core-side model: issues SFR writes and reads as processor firmware would.
// Assumes one-cycle strobes that the bank samples on the rising edge of clk.
module sfr_core_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // ==========================================================
    // Bus cycles
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d; // Whole byte on every write
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        d = rdata;
        rd = 1'b0;
        addr = ~a;
    endtask : sfr_read
endmodule : sfr_core_model

/* File: sim/tb_sfr_bank.sv */
// Self-checking bench for the SFR bank, random data from a fixed seed.
// Assumes the core model drives the bus; bench drives events and pin levels.
module tb_sfr_bank;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic sys_rst, wr, rd, irq_en, dbg_en, preboot, byte_done, xfer_evt, sec_evt, loss_evt;
    logic [7:0] addr, wdata, rdata, ee_status, ee_data, ee_cmd, page, v, rv;
    logic [6:0] ext_irq, erase_page;
    logic pg_start, ms_start, pwe, protect, ee_launch, wd_restart, xfer_f, sec_f, loss_f;
    int failures = 0;
    int checks = 0;
    int seed = 58580;
    always #12.5 clk = ~clk;
    sfr_core_model core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    sfr_bank dut (.CLK(clk), .SYS_RST(sys_rst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .IRQ_GLOBAL_EN(irq_en),
        .DEBUG_PORT_EN(dbg_en), .PREBOOT_ACTIVE(preboot), .FLASH_BYTE_DONE(byte_done),
        .TRANSFER_BUSY_EVENT(xfer_evt), .SECONDS_TICK_EVENT(sec_evt),
        .CLOCK_LOSS_EVENT(loss_evt), .EXT_IRQ_LINES(ext_irq), .EEPROM_STATUS(ee_status),
        .PAGE_ERASE_START(pg_start), .MASS_ERASE_START(ms_start), .ERASE_PAGE(erase_page),
        .PROGRAM_SPACE_WRITE_ENABLE(pwe), .READOUT_PROTECT(protect), .EEPROM_DATA(ee_data),
        .EEPROM_COMMAND(ee_cmd), .EEPROM_LAUNCH(ee_launch), .WATCHDOG_RESTART(wd_restart),
        .TRANSFER_IRQ_FLAG(xfer_f), .ONE_SECOND_IRQ_FLAG(sec_f), .CLOCK_LOSS_FLAG(loss_f));
    // ==========================================================
    // Expectations and checks
    function automatic logic [7:0] exp_ctl(input logic pb, input logic pr, input logic pw);
        return {pb, pr, 5'b00000, pw};
    endfunction : exp_ctl
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        core.sfr_read(a, rv);
        chk(rv, exp);
    endtask : rchk
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic final_report;
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // ==========================================================
    // Main sequence
    initial
    begin
        {sys_rst, irq_en, dbg_en, preboot, byte_done, xfer_evt, sec_evt, loss_evt} = 8'h80;
        ext_irq = 7'h00;
        ee_status = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        rchk(sfr_bank_pkg::ADDR_PAGE_SELECT, 8'h00);
        rchk(sfr_bank_pkg::ADDR_FLASH_CONTROL, exp_ctl(1'b0, 1'b0, 1'b0));
        rchk(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'h00);
        rchk(8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            page = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
            core.sfr_write(sfr_bank_pkg::ADDR_PAGE_SELECT, page);
            chk(erase_page, page);
            core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'h55);
            chk(pg_start, 1'b1);
            rchk(sfr_bank_pkg::ADDR_PAGE_SELECT, page);
            chk(pg_start, 1'b0);
            core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'h55);
            chk(pg_start, 1'b0);
        end
        dbg_en = 1'b1;
        settle();
        core.sfr_write(sfr_bank_pkg::ADDR_FLASH_CONTROL, 8'h02);
        core.sfr_write(sfr_bank_pkg::ADDR_PAGE_SELECT, 8'h21);
        for (int i = 0; i < 6; i++)
        begin
            v = 8'($random(seed));
            if (v == 8'h55 || v == 8'hAA)
                v = 8'h00;
            core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, v);
            chk({pg_start, ms_start}, 8'h00);
        end
        core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'h55);
        chk(pg_start, 1'b1);
        core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'hAA);
        chk(ms_start, 1'b1);
        core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'hAA);
        chk(ms_start, 1'b0);
        dbg_en = 1'b0;
        settle();
        core.sfr_write(sfr_bank_pkg::ADDR_FLASH_CONTROL, 8'h02);
        core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'hAA);
        chk(ms_start, 1'b0);
        irq_en = 1'b1;
        core.sfr_write(sfr_bank_pkg::ADDR_FLASH_CONTROL, 8'h01);
        chk(pwe, 1'b0);
        irq_en = 1'b0;
        core.sfr_write(sfr_bank_pkg::ADDR_FLASH_CONTROL, 8'h01);
        chk(pwe, 1'b1);
        byte_done = 1'b1;
        @(posedge clk);
        #1;
        byte_done = 1'b0;
        chk(pwe, 1'b0);
        preboot = 1'b1;
        core.sfr_write(sfr_bank_pkg::ADDR_FLASH_CONTROL, 8'h40);
        core.sfr_write(sfr_bank_pkg::ADDR_FLASH_CONTROL, 8'h00);
        chk(protect, 1'b1);
        rchk(sfr_bank_pkg::ADDR_FLASH_CONTROL, exp_ctl(1'b1, 1'b1, 1'b0));
        preboot = 1'b0;
        v = 8'($random(seed));
        ee_status = 8'($random(seed));
        core.sfr_write(sfr_bank_pkg::ADDR_EEPROM_DATA, v);
        chk(ee_data, v);
        core.sfr_write(sfr_bank_pkg::ADDR_EEPROM_CMD, ~v);
        chk(ee_launch, 1'b1);
        chk(ee_cmd, ~v);
        rchk(sfr_bank_pkg::ADDR_EEPROM_DATA, v);
        rchk(sfr_bank_pkg::ADDR_EEPROM_CMD, ee_status);
        {xfer_evt, sec_evt, loss_evt} = 3'b111;
        @(posedge clk);
        #1;
        {xfer_evt, sec_evt, loss_evt} = 3'b000;
        chk({xfer_f, sec_f}, 8'h03);
        rchk(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'h83);
        core.sfr_write(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'hFE);
        chk({wd_restart, xfer_f, loss_f}, 8'h05);
        core.sfr_write(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'h7F);
        chk(wd_restart, 1'b0);
        rchk(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'h02);
        core.sfr_write(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'hFD);
        chk(sec_f, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            ext_irq = 7'($random(seed));
            settle();
            rchk(sfr_bank_pkg::ADDR_IRQ_VIEW, {1'b0, ext_irq});
        end
        fork
            core.sfr_write(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'h7E);
            begin
                @(posedge clk);
                #1;
                xfer_evt = 1'b1;
                @(posedge clk);
                #1;
                xfer_evt = 1'b0;
            end
        join
        chk(xfer_f, 1'b1);
        rchk(sfr_bank_pkg::ADDR_MULTI_FLAG, 8'h01);
        core.sfr_write(sfr_bank_pkg::ADDR_PAGE_SELECT, 8'h33);
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk(protect, 1'b0);
        chk(erase_page, 8'h00);
        chk(xfer_f, 1'b0);
        core.sfr_write(sfr_bank_pkg::ADDR_ERASE_TRIGGER, 8'h55);
        chk(pg_start, 1'b0);
        final_report();
    end
endmodule : tb_sfr_bank
